// ==== include/sps_pkg.sv ====
package sps_pkg;

  // Clock and power-on timing
  localparam int SPS_CLK_MHZ      = 200;       // pclk rate in MHz
  localparam int SPS_POR_DELAY_US = 500;       // Standby valid time, in us
  localparam int SPS_POR_CYCLES   = SPS_POR_DELAY_US * SPS_CLK_MHZ;

  // Register indexes; byte address is four times the index
  localparam logic [2:0] SPS_IDX_CTRL_A = 3'h2;  // Slot A control
  localparam logic [2:0] SPS_IDX_CTRL_B = 3'h3;  // Slot B control
  localparam logic [2:0] SPS_IDX_STAT_A = 3'h4;  // Slot A status
  localparam logic [2:0] SPS_IDX_STAT_B = 3'h5;  // Slot B status
  localparam logic [2:0] SPS_IDX_CSTAT  = 3'h6;  // Common status
  localparam logic [2:0] SPS_IDX_ADDR   = 3'h7;  // Latched serial address

  // Slot control fields
  localparam int SPS_CTRL_AUX_EN  = 0;  // Auxiliary enable
  localparam int SPS_CTRL_MAIN_EN = 1;  // Main enable
  localparam int SPS_CTRL_MAIN_PG = 6;  // Main power-good
  localparam int SPS_CTRL_AUX_PG  = 7;  // Auxiliary power-good

  // Slot status fields, bits 4..0 are individual faults
  localparam int SPS_ST_UV      = 0;  // Input undervoltage
  localparam int SPS_ST_FAST    = 1;  // Fast trip
  localparam int SPS_ST_SLOW    = 2;  // Slow trip after timeout
  localparam int SPS_ST_SLOT_OT = 3;  // Slow trip with slot overtemp
  localparam int SPS_ST_AUX_OC  = 4;  // Auxiliary overcurrent
  localparam int SPS_ST_SUMMARY = 7;  // Summary fault, pin mode only

  // Common status fields
  localparam int SPS_CS_OT   = 1;  // Global overtemperature
  localparam int SPS_CS_STUV = 2;  // Standby undervoltage
  localparam int SPS_CS_MASK = 3;  // Interrupt mask
  localparam int SPS_CS_GPI0 = 4;  // First general input level
  localparam int SPS_CS_GPI1 = 5;  // Second general input level

  // Values after reset
  localparam logic [1:0] SPS_CTRL_RST = 2'h0;
  localparam logic [7:0] SPS_STAT_RST = 8'h00;
  localparam logic       SPS_MASK_RST = 1'b1;

  // Upper serial address bits above the three strap bits
  localparam logic [3:0] SPS_ADDR_HIGH = 4'h8;

  // Analog indications of one slot, already qualified by comparators
  typedef struct packed {
    logic main_uv;     // Any main supply input below threshold
    logic fast_trip;   // Fast-trip comparator fired
    logic slow_oc;     // Slow current limit exceeded
    logic oc_timeout;  // Overcurrent timer expired
    logic aux_oc;      // Auxiliary output in current limit
    logic slot_ot;     // Slot temperature at slot limit
    logic main_pg;     // All four main outputs above power-good
    logic aux_pg;      // Auxiliary output above power-good
  } sps_slot_in_t;

  // Results of one slot guard
  typedef struct packed {
    logic       main_en;    // Main supplies switched on
    logic       aux_en;     // Auxiliary supply switched on
    logic       fault_pin;  // Fault pin asserted
    logic       fault_new;  // Fault pin asserted this cycle
    logic [4:0] events;     // Fault events for the status bits
  } sps_slot_out_t;

  // Power-on sequence
  typedef enum logic {SPS_POR_WAIT, SPS_RUN} sps_por_state_t;

endpackage

// ==== verification/sps_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Hot-plug host: turns bench requests into enable pin levels
module sps_host_model #(
  parameter int HOLD = 24  // Cycles after reset before pins may rise
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] want_main,
  input  wire logic [1:0] want_aux,
  output logic      [1:0] main_on_pin,
  output logic      [1:0] slot_aux_enable_pin
);
  int unsigned wait_cnt;  // Cycles since reset released

  // Pins stay low until the power-on delay is over; a request that
  // drops releases the pin, which is how the host clears a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt            <= 0;
      main_on_pin         <= 2'h0;
      slot_aux_enable_pin <= 2'h0;
    end else begin
      if (wait_cnt < HOLD) begin
        wait_cnt <= wait_cnt + 1;
      end
      main_on_pin         <= (wait_cnt >= HOLD) ? want_main : 2'h0;
      slot_aux_enable_pin <= (wait_cnt >= HOLD) ? want_aux : 2'h0;
    end
  end
endmodule  // sps_host_model
`default_nettype wire

// ==== verification/sps_supervisor_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module sps_supervisor_chk
  import sps_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  input  wire logic               pready,
  input  wire sps_slot_in_t [1:0] slot_in,
  input  wire logic               die_overtemp,
  input  wire logic [1:0]         main_on_pin,
  input  wire logic [1:0]         slot_aux_enable_pin,
  input  wire logic [1:0]         main_supply_en,
  input  wire logic [1:0]         aux_supply_out,
  input  wire logic [1:0]         fault_pin_n_oe,
  input  wire logic               irq_n_oe,
  input  wire logic [6:0]         serial_addr
);
  logic mask_reg;   // Shadow of the interrupt mask
  logic mask_next;  // Its next value

  // Only a completed, strobed write to common status moves the mask
  always_comb begin
    mask_next = mask_reg;
    if (psel && penable && pready && pwrite && pstrb[0]
        && paddr == {27'h000_0000, SPS_IDX_CSTAT, 2'h0}) begin
      mask_next = pwdata[SPS_CS_MASK];
    end
  end

  // Register the shadow; reset value matches the design's mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= SPS_MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Five cycles cover two sync flops plus the output register
  slow_trip_a: assert property (
    (slot_in[1].slow_oc && slot_in[1].oc_timeout) [*5] |-> !main_supply_en[1])
    else $error("slow overcurrent left main on");
  fast_trip_a: assert property (
    slot_in[0].fast_trip [*5] |-> !main_supply_en[0])
    else $error("fast trip left main on");
  aux_trip_a: assert property (
    (slot_in[0].aux_oc && slot_in[0].oc_timeout) [*5] |-> !aux_supply_out[0])
    else $error("aux overcurrent left aux on");
  slot_hot_a: assert property (
    slot_in[1].slot_ot [*5] |-> !aux_supply_out[1] && !main_supply_en[1])
    else $error("slot overtemp left outputs on");
  die_hot_a: assert property (
    die_overtemp [*5] |-> main_supply_en == 2'h0 && aux_supply_out == 2'h0)
    else $error("die overtemp left outputs on");
  fault_release_a: assert property (
    (!main_on_pin[1] && !slot_aux_enable_pin[1]) [*5] |-> !fault_pin_n_oe[1])
    else $error("fault pin held with enables low");
  irq_masked_a: assert property (
    mask_reg && $past(mask_reg) |-> !irq_n_oe)
    else $error("interrupt while masked");
  addr_latched_a: assert property (
    serial_addr != 7'h00 |=> $stable(serial_addr))
    else $error("serial address moved after latch");
endmodule  // sps_supervisor_chk

bind sps_supervisor sps_supervisor_chk u_sps_supervisor_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .slot_in, .die_overtemp, .main_on_pin, .slot_aux_enable_pin,
  .main_supply_en, .aux_supply_out, .fault_pin_n_oe, .irq_n_oe,
  .serial_addr
);
`default_nettype wire

// ==== verification/test_slot_power_fault_supervisor.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_slot_power_fault_supervisor
  import sps_pkg::*;
;
  localparam int POR = 20;  // Short power-on wait keeps the run brief
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic die_overtemp, standby_uv, standby_supply_in, irq_n_o, irq_n_oe;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] addr_strap_pins;
  logic [6:0] serial_addr;
  logic [1:0] want_main, want_aux, main_on_pin, slot_aux_enable_pin, pg;
  logic [1:0] general_input_pin, main_supply_en, aux_supply_out;
  logic [1:0] fault_pin_n_o, fault_pin_n_oe;
  sps_slot_in_t [1:0] slot_in;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  integer seed = 32'h9688;

  sps_supervisor #(.POR_CYCLES(POR)) u_sps_supervisor (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .slot_in, .die_overtemp, .standby_uv, .standby_supply_in,
    .main_on_pin, .slot_aux_enable_pin, .general_input_pin,
    .addr_strap_pins, .main_supply_en, .aux_supply_out, .fault_pin_n_o,
    .fault_pin_n_oe, .irq_n_o, .irq_n_oe, .serial_addr);
  sps_host_model #(.HOLD(POR + 4)) u_sps_host_model (.pclk, .presetn,
    .want_main, .want_aux, .main_on_pin, .slot_aux_enable_pin);

  always #2.5 pclk = ~pclk;

  // Hang guard: far above the roughly one thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; a pready that never comes is caught only by the guard
  task automatic apb(input logic w, input logic [2:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {27'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] i, input logic [7:0] exp);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Fault inputs per kind: UV, fast, slow+timeout, slot OT, aux+timeout
  function automatic logic [7:0] fault_of(input int k);
    logic [7:0] tbl [5] = '{8'h80, 8'h40, 8'h30, 8'h24, 8'h18};
    return tbl[k];
  endfunction

  // Main survives only an aux fault; aux survives the main-only faults
  function automatic logic [1:0] kept(input int k);
    return {k < 3, k == 4};
  endfunction

  // Trip one slot with one fault kind, then clear and re-enable it
  task automatic fault_test(input int s, input int k);
    logic [2:0] c;
    logic [2:0] st;
    c = SPS_IDX_CTRL_A + 3'(s);
    st = SPS_IDX_STAT_A + 3'(s);
    pg = 2'($random(seed));
    apb(1'b1, c, 8'h00);
    slot_in[s] <= 8'h80 | {6'h0, pg};
    idle(8);
    slot_in[s] <= {6'h0, pg};
    rdc(st, 8'h00);
    apb(1'b1, c, 8'h03);
    idle(8);
    chk({aux_supply_out[s], main_supply_en[s]}, 2'h3);
    rdc(c, {pg[0], pg[1], 6'h03});
    slot_in[s] <= fault_of(k) | {6'h0, pg};
    idle(8);
    chk({aux_supply_out[s], main_supply_en[s]}, kept(k));
    chk(main_supply_en[1-s], 1'b1);
    chk(fault_pin_n_oe, 2'h0);
    slot_in[s] <= {6'h0, pg};
    idle(8);
    chk(irq_n_oe, 1'b1);
    chk({aux_supply_out[s], main_supply_en[s]}, kept(k));
    apb(1'b1, st, ~(8'h01 << k) & 8'h1f);
    rdc(st, 8'h01 << k);
    apb(1'b1, st, 8'h01 << k);
    idle(4);
    rdc(st, 8'h00);
    chk(irq_n_oe, 1'b0);
    apb(1'b1, c, 8'h00);
    apb(1'b1, c, 8'h03);
    idle(8);
    chk({aux_supply_out[s], main_supply_en[s]}, 2'h3);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, die_overtemp, standby_uv} = 6'h00;
    {paddr, pwdata} = 64'h0;
    {want_main, want_aux} = 4'h0;
    pstrb = 4'h1;
    standby_supply_in = 1'b1;
    slot_in = 16'h0000;
    general_input_pin = 2'($random(seed));
    addr_strap_pins = 3'($random(seed));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, SPS_IDX_CTRL_A, 8'h03);
    idle(POR + 8);
    chk(main_supply_en, 2'h0);
    rdc(SPS_IDX_CTRL_A, 8'h00);
    rdc(SPS_IDX_STAT_B, 8'h00);
    apb(1'b0, 3'h1, 8'h00);
    chk(err, 1'b1);
    chk(serial_addr, {SPS_ADDR_HIGH, addr_strap_pins});
    addr_strap_pins <= ~addr_strap_pins;
    repeat (4) begin
      general_input_pin <= 2'($random(seed));
      idle(4);
      rdc(SPS_IDX_CSTAT, {2'h0, general_input_pin, 4'h8});
    end
    done("reset");
    apb(1'b1, SPS_IDX_CSTAT, 8'h00);
    apb(1'b1, SPS_IDX_CTRL_A, 8'h03);
    apb(1'b1, SPS_IDX_CTRL_B, 8'h03);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 5; k++) begin
        fault_test(s, k);
      end
    end
    done("faults");
    // Slot B through the hot-plug pins
    apb(1'b1, SPS_IDX_CTRL_B, 8'h00);
    want_main <= 2'h2;
    want_aux  <= 2'h2;
    idle(8);
    chk({aux_supply_out[1], main_supply_en[1]}, 2'h3);
    slot_in[1] <= 8'h40;
    idle(8);
    chk({aux_supply_out[1], main_supply_en[1]}, 2'h2);
    chk(fault_pin_n_oe, 2'h2);
    slot_in[1] <= 8'h00;
    idle(8);
    chk(fault_pin_n_oe, 2'h2);
    rdc(SPS_IDX_STAT_B, 8'h82);
    want_main <= 2'h0;
    want_aux  <= 2'h0;
    idle(8);
    chk(fault_pin_n_oe, 2'h0);
    apb(1'b1, SPS_IDX_STAT_B, 8'h82);
    rdc(SPS_IDX_STAT_B, 8'h00);
    done("pins");
    apb(1'b1, SPS_IDX_CTRL_B, 8'h03);
    idle(8);
    die_overtemp <= 1'b1;
    standby_uv   <= 1'b1;
    idle(8);
    chk({aux_supply_out, main_supply_en}, 4'h0);
    die_overtemp <= 1'b0;
    standby_uv   <= 1'b0;
    rdc(SPS_IDX_CSTAT, {2'h0, general_input_pin, 4'h6});
    apb(1'b1, SPS_IDX_CSTAT, 8'h06);
    rdc(SPS_IDX_CSTAT, {2'h0, general_input_pin, 4'h0});
    chk(serial_addr, {SPS_ADDR_HIGH, ~addr_strap_pins});
    done("overtemp");
    // Cycle slot A back on, then lose standby in mid-run
    apb(1'b1, SPS_IDX_CTRL_A, 8'h00);
    apb(1'b1, SPS_IDX_CTRL_A, 8'h03);
    idle(8);
    chk(main_supply_en, 2'h1);
    standby_supply_in <= 1'b0;
    idle(8);
    chk({aux_supply_out, main_supply_en}, 4'h0);
    chk({fault_pin_n_o, irq_n_o, irq_n_oe}, 4'h0);
    rdc(SPS_IDX_CSTAT, {2'h0, general_input_pin, 4'h8});
    done("standby");
    results();
  end
endmodule  // test_slot_power_fault_supervisor
`default_nettype wire

// ==== verilog/sps_slot_guard.sv ====
`timescale 1ns/10ps
`default_nettype none
module sps_slot_guard
  import sps_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          run,        // Power-on reset finished
  input  wire logic          main_req,   // Main enable, pin or register
  input  wire logic          aux_req,    // Aux enable, pin or register
  input  wire logic          pin_mode,   // Enabled through hot-plug pins
  input  wire logic          global_ot,  // Die above global limit
  input  wire sps_slot_in_t  sin,
  output var  sps_slot_out_t sout
);

  logic main_req_q_reg, main_req_q_next;  // Previous main request
  logic main_trip_reg, main_trip_next;    // Main breaker tripped
  logic aux_trip_reg, aux_trip_next;      // Aux breaker tripped
  sps_slot_out_t sout_reg, sout_next;
  logic f_uv, f_fast, f_slow, f_ot, f_aux;

  // Trip detection and enable tracking
  always_comb begin
    f_uv   = sin.main_uv & sout_reg.main_en;
    f_fast = sin.fast_trip & sout_reg.main_en;
    f_slow = sin.slow_oc & sin.oc_timeout & sout_reg.main_en;
    f_ot   = sin.slot_ot;
    f_aux  = sin.aux_oc & sin.oc_timeout & sout_reg.aux_en;
    main_req_q_next = main_req;
    // A trip holds until the enable drops, so only a cycle re-arms
    main_trip_next = main_req &
      (main_trip_reg | f_uv | f_fast | f_slow | f_ot | global_ot);
    aux_trip_next  = aux_req &
      (aux_trip_reg | f_aux | f_ot | global_ot);
    sout_next = sout_reg;
    if (!run || !main_req || main_trip_next) begin
      sout_next.main_en = 1'b0;
    end else if (!main_req_q_reg && !sin.main_uv) begin
      sout_next.main_en = 1'b1;
    end
    sout_next.aux_en = run & aux_req & ~aux_trip_next;
    // Fault pin only in pin mode; released when pins drop
    sout_next.fault_new = 1'b0;
    if (!pin_mode || !run) begin
      sout_next.fault_pin = 1'b0;
    end else if ((main_trip_next & ~main_trip_reg) |
                 (aux_trip_next & ~aux_trip_reg)) begin
      sout_next.fault_pin = 1'b1;
      sout_next.fault_new = 1'b1;
    end
    // Fault events count only while an enable is set
    sout_next.events = {f_aux, f_ot & sin.slow_oc, f_slow, f_fast, f_uv}
                       & {5{run & (main_req | aux_req)}};
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_req_q_reg <= 1'b0;
      main_trip_reg  <= 1'b0;
      aux_trip_reg   <= 1'b0;
      sout_reg       <= '0;
    end else begin
      main_req_q_reg <= main_req_q_next;
      main_trip_reg  <= main_trip_next;
      aux_trip_reg   <= aux_trip_next;
      sout_reg       <= sout_next;
    end
  end

  assign sout = sout_reg;

endmodule // sps_slot_guard
`default_nettype wire

// ==== verilog/sps_supervisor.sv ====
`timescale 1ns/10ps
`default_nettype none
module sps_supervisor
  import sps_pkg::*;
#(
  parameter int POR_CYCLES = SPS_POR_CYCLES  // Standby valid time, cycles
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog side, asynchronous to pclk
  input  wire sps_slot_in_t [1:0] slot_in,
  input  wire logic              die_overtemp,
  input  wire logic              standby_uv,
  input  wire logic              standby_supply_in,
  // Hot-plug pins and straps
  input  wire logic [1:0]        main_on_pin,
  input  wire logic [1:0]        slot_aux_enable_pin,
  input  wire logic [1:0]        general_input_pin,
  input  wire logic [2:0]        addr_strap_pins,
  // Supply controls
  output logic      [1:0]        main_supply_en,
  output logic      [1:0]        aux_supply_out,
  // Open-drain active-low fault pins and interrupt
  output logic      [1:0]        fault_pin_n_o,
  output logic      [1:0]        fault_pin_n_oe,
  output logic                   irq_n_o,
  output logic                   irq_n_oe,
  // Latched serial-bus address
  output logic      [6:0]        serial_addr
);

  localparam int SYNC_W  = 28;  // Width of all asynchronous inputs
  localparam int POR_W   = 17;  // Width of the power-on counter
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

  // Two-stage synchroniser for every pin and analog indication
  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic [SYNC_W-1:0] raw_in;

  // Synchronised views
  sps_slot_in_t [1:0] sin;
  logic       s_die_ot;
  logic       s_stuv;
  logic       s_stby;
  logic [1:0] s_on;
  logic [1:0] s_auxen;
  logic [1:0] s_gpi;
  logic [2:0] s_strap;

  // Power-on sequence state
  sps_por_state_t   por_state_reg, por_state_next;
  logic [POR_W-1:0] por_cnt_reg, por_cnt_next;
  logic [6:0]       addr_reg, addr_next;
  logic             run;

  // Software registers
  logic [1:0] ctrl_reg [2];   // Per slot: main and aux enable bits
  logic [1:0] ctrl_next [2];
  logic [7:0] stat_reg [2];   // Per slot status
  logic [7:0] stat_next [2];
  logic [2:1] cs_flag_reg, cs_flag_next;  // Common fault flags
  logic       mask_reg, mask_next;        // Interrupt mask

  // Bus answer registers
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        irq_oe_reg, irq_oe_next;
  logic        od_level_reg;  // Drive level of open-drain outputs

  // Bus decode
  logic       setup;
  logic       wr_en;
  logic [2:0] idx;
  logic       mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // Slot guard connections
  logic [1:0]          main_req;
  logic [1:0]          aux_req;
  logic [1:0]          pin_mode;
  sps_slot_out_t [1:0] sout;

  // Gather inputs for the synchroniser
  assign raw_in = {slot_in, die_overtemp, standby_uv, standby_supply_in,
                   main_on_pin, slot_aux_enable_pin, general_input_pin,
                   addr_strap_pins};

  // The first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Split the synchronised vector
  assign {sin, s_die_ot, s_stuv, s_stby, s_on, s_auxen, s_gpi, s_strap}
    = sync2_reg;

  // Power-on delay: standby must stay valid for the full count
  always_comb begin
    por_state_next = por_state_reg;
    por_cnt_next   = por_cnt_reg;
    addr_next      = addr_reg;
    case (por_state_reg)
      SPS_POR_WAIT: begin
        if (!s_stby) begin
          por_cnt_next = '0;
        end else if (por_cnt_reg == POR_LAST) begin
          por_state_next = SPS_RUN;
          // Straps are taken once, at the end of power-up
          addr_next = {SPS_ADDR_HIGH, s_strap};
        end else begin
          por_cnt_next = por_cnt_reg + 1'b1;
        end
      end
      SPS_RUN: begin
        // Losing standby starts a fresh power-on cycle
        if (!s_stby) begin
          por_state_next = SPS_POR_WAIT;
          por_cnt_next   = '0;
        end
      end
      default: begin
        por_state_next = SPS_POR_WAIT;
        por_cnt_next   = '0;
      end
    endcase
  end

  // Power-on registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_state_reg <= SPS_POR_WAIT;
      por_cnt_reg   <= '0;
      addr_reg      <= 7'h00;
    end else begin
      por_state_reg <= por_state_next;
      por_cnt_reg   <= por_cnt_next;
      addr_reg      <= addr_next;
    end
  end

  assign run = (por_state_reg == SPS_RUN);

  // Enable sources: pins or control bits, either one requests power
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      pin_mode[s] = s_on[s] | s_auxen[s];
      main_req[s] = s_on[s] | ctrl_reg[s][SPS_CTRL_MAIN_EN];
      aux_req[s]  = s_auxen[s] | ctrl_reg[s][SPS_CTRL_AUX_EN];
    end
  end

  // One independent guard per slot
  generate
    for (genvar g = 0; g < 2; g++) begin : g_slot
      sps_slot_guard u_guard (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (run),
        .main_req  (main_req[g]),
        .aux_req   (aux_req[g]),
        .pin_mode  (pin_mode[g]),
        .global_ot (s_die_ot),
        .sin       (sin[g]),
        .sout      (sout[g])
      );
    end
  endgenerate

  // APB decode; writes land on the access edge with pready high
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready_reg & pwrite & ~pslverr_reg
                  & pstrb[0];
  assign idx    = paddr[4:2];
  assign mapped = (paddr[31:5] == 27'h000_0000) && (paddr[1:0] == 2'h0)
                  && (idx >= SPS_IDX_CTRL_A);
  assign wbyte  = pwdata[7:0];

  // Register next state: hardware set wins over software clear
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      ctrl_next[s] = ctrl_reg[s];
      stat_next[s] = stat_reg[s];
      if (wr_en && idx == SPS_IDX_CTRL_A + 3'(s)) begin
        ctrl_next[s] = wbyte[1:0];
      end
      if (wr_en && idx == SPS_IDX_STAT_A + 3'(s)) begin
        stat_next[s] = stat_reg[s] & ~wbyte;
      end
      stat_next[s][4:0] = stat_next[s][4:0] | sout[s].events;
      if (sout[s].fault_new) begin
        stat_next[s][SPS_ST_SUMMARY] = 1'b1;
      end
      stat_next[s][6:5] = 2'h0;
      if (!run) begin
        ctrl_next[s] = SPS_CTRL_RST;
        stat_next[s] = SPS_STAT_RST;
      end
    end
    cs_flag_next = cs_flag_reg;
    mask_next    = mask_reg;
    if (wr_en && idx == SPS_IDX_CSTAT) begin
      cs_flag_next = cs_flag_reg & ~wbyte[2:1];
      mask_next    = wbyte[SPS_CS_MASK];
    end
    if (s_die_ot && (|main_req || |aux_req)) begin
      cs_flag_next[SPS_CS_OT] = 1'b1;
    end
    if (s_stuv && (|main_req || |aux_req)) begin
      cs_flag_next[SPS_CS_STUV] = 1'b1;
    end
    if (!run) begin
      cs_flag_next = 2'h0;
      mask_next    = SPS_MASK_RST;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg[0] <= SPS_CTRL_RST;
      ctrl_reg[1] <= SPS_CTRL_RST;
      stat_reg[0] <= SPS_STAT_RST;
      stat_reg[1] <= SPS_STAT_RST;
      cs_flag_reg <= 2'h0;
      mask_reg    <= SPS_MASK_RST;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      cs_flag_reg <= cs_flag_next;
      mask_reg    <= mask_next;
    end
  end

  // Read data mux; power-good bits are live status
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      SPS_IDX_CTRL_A, SPS_IDX_CTRL_B: begin
        rbyte[1:0] = ctrl_reg[idx[0]];
        rbyte[SPS_CTRL_MAIN_PG] = sin[idx[0]].main_pg;
        rbyte[SPS_CTRL_AUX_PG]  = sin[idx[0]].aux_pg;
      end
      SPS_IDX_STAT_A, SPS_IDX_STAT_B: begin
        rbyte = stat_reg[idx[0]];
      end
      SPS_IDX_CSTAT: begin
        rbyte[2:1]         = cs_flag_reg;
        rbyte[SPS_CS_MASK] = mask_reg;
        rbyte[SPS_CS_GPI0] = s_gpi[0];
        rbyte[SPS_CS_GPI1] = s_gpi[1];
      end
      SPS_IDX_ADDR: begin
        rbyte[6:0] = addr_reg;
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
  end

  // Answer one cycle after setup, so pready is high on the first
  // access cycle; unmapped addresses answer with an error
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup & ~mapped;
    prdata_next  = 32'h0000_0000;
    if (setup && mapped && !pwrite) begin
      prdata_next = {24'h00_0000, rbyte};
    end
    // Any pending fault except the summary bit drives the interrupt once unmasked
    irq_oe_next = run & ~mask_reg &
      (|stat_reg[0][4:0] | |stat_reg[1][4:0] | |cs_flag_reg);
  end

  // Bus answer and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      irq_oe_reg   <= 1'b0;
      od_level_reg <= 1'b0;
    end else begin
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      irq_oe_reg   <= irq_oe_next;
      od_level_reg <= 1'b0;
    end
  end

  // Outputs, all from registers
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_n_o  = od_level_reg;
  assign irq_n_oe = irq_oe_reg;
  assign serial_addr = addr_reg;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      main_supply_en[s] = sout[s].main_en;
      aux_supply_out[s] = sout[s].aux_en;
      fault_pin_n_o[s]  = od_level_reg;
      fault_pin_n_oe[s] = sout[s].fault_pin;
    end
  end

endmodule // sps_supervisor
`default_nettype wire
